// ### pkg/stls_pkg.sv
// stls_pkg: constants and carrier types for the torque-limit select block.
// assumes a single 10 MHz system clock and a plain strobe register port.
package stls_pkg;
	localparam int STLS_CLK_MHZ = 10;
	// register offsets (word index equals byte address on this plain port)
	localparam logic [7:0] STLS_OFS_SYS_CFG = 8'h00;
	localparam logic [7:0] STLS_OFS_GAIN = 8'h01;
	localparam logic [7:0] STLS_OFS_OFFSET = 8'h02;
	localparam logic [7:0] STLS_OFS_CTRL = 8'h03;
	localparam logic [7:0] STLS_OFS_TUNE = 8'h04;
	localparam logic [7:0] STLS_OFS_RIGID = 8'h05;
	localparam logic [7:0] STLS_OFS_INERTIA = 8'h06;
	localparam logic [7:0] STLS_OFS_POSGAIN = 8'h07;
	localparam logic [7:0] STLS_OFS_SPDGAIN = 8'h08;
	localparam logic [7:0] STLS_OFS_SPDINT = 8'h09;
	localparam logic [7:0] STLS_OFS_FFWD = 8'h0A;
	localparam logic [7:0] STLS_OFS_STATUS = 8'h0B;
	localparam logic [7:0] STLS_OFS_LIMIT0 = 8'h10;
	// field positions
	localparam int STLS_BIT_ANALOG_EN = 0;
	localparam int STLS_BIT_AUTO_OFS = 1;
	localparam int STLS_BIT_SERVO_LOCK = 2;
	localparam int STLS_BIT_APPLY = 0;
	localparam int STLS_BIT_POWER_CYCLE = 1;
	// reset values and limits
	localparam logic [15:0] STLS_GAIN_RESET = 16'h001E;
	localparam logic [15:0] STLS_GAIN_MAX = 16'h012C;
	localparam logic [15:0] STLS_LIMIT_MAX = 16'h012C;
	localparam logic [15:0] STLS_LIMIT_RESET = 16'h0000;
	localparam logic [15:0] STLS_FULL_TORQUE = 16'h012C;
	localparam logic [15:0] STLS_MV_PER_V = 16'h03E8;
	localparam logic [15:0] STLS_AUTO_INERTIA_MAX = 16'h0032;
	localparam logic [15:0] STLS_MANUAL_INERTIA_MAX = 16'h0064;
	localparam logic [2:0] STLS_SET_ANALOG_LAST = 3'h1;

	typedef enum logic [1:0]
	{
		STLS_TUNE_AUTO = 2'b00,
		STLS_TUNE_SEMI = 2'b01,
		STLS_TUNE_MANUAL = 2'b10
	} stls_tune_type;

	typedef struct packed
	{
		logic [15:0] posGain;
		logic [15:0] spdGain;
		logic [15:0] spdInt;
		logic [15:0] feedFwd;
		logic [15:0] rigidity;
		logic [15:0] inertia;
		logic useEstimate;
	} stls_gains_type;
endpackage : stls_pkg

// ### rtl/stls_core.sv
// stls_core: torque-limit data-set selection, analog limit scaling and
// gain-tuning parameter selection. registers on a plain strobe port; the
// select and clamp-enable pins arrive asynchronously and are synchronised.
`timescale 1ns/1ps
module stls_core
	import stls_pkg::*;
#(
	parameter int SETS = 8,
	parameter int AW = 8
)
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [AW-1:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [15:0] regRdData_q,
	input wire logic data_select_bit0,
	input wire logic data_select_bit1,
	input wire logic data_select_bit2,
	input wire logic torque_clamp_enable_in,
	input wire logic [15:0] analogMilliVolt,
	input wire logic [15:0] producedTorque,
	input wire logic [15:0] estInertia,
	output logic [15:0] torqueMax_q,
	output logic torque_clamped_status_out,
	output stls_gains_type gains_q
);
	initial
	begin
		if (SETS != 8)
			$error("stls_core: exactly eight data sets are supported");
		if (AW < 5 || AW > 8)
			$error("stls_core: address width must be 5 to 8 for the map");
	end

	logic [2:0] pinMeta_q;
	logic [2:0] pinSync_q;
	logic clampMeta_q;
	logic clampSync_q;
	logic [15:0] limits_q [SETS];
	logic [15:0] gain_q, offsetParam_q, capOffset_q;
	logic [2:0] sysPend_q, sysCfg_q;
	stls_tune_type tune_q;
	logic [15:0] rigid_q, inertia_q, posGain_q, spdGain_q, spdInt_q, ffwd_q;
	logic [15:0] activeLimit;
	logic [31:0] analogLimit;
	logic [15:0] zeroRef, deltaMv;
	logic [2:0] setSel;
	logic torqueClampedQ;

	function automatic logic [15:0] clampTo(input logic [15:0] v, input logic [15:0] mx);
		clampTo = (v > mx) ? mx : v;
	endfunction : clampTo

	function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] ofs);
		hit = (a == AW'(ofs));
	endfunction : hit

	// pin synchronisers; second stage feeds all logic
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			pinMeta_q <= 3'h0;
			pinSync_q <= 3'h0;
			clampMeta_q <= 1'b0;
			clampSync_q <= 1'b0;
		end
		else
		begin
			pinMeta_q <= {data_select_bit2, data_select_bit1, data_select_bit0};
			pinSync_q <= pinMeta_q;
			clampMeta_q <= torque_clamp_enable_in;
			clampSync_q <= clampMeta_q;
		end
	end

	assign setSel = pinSync_q;

	// pending system config takes effect on power cycle only
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			sysPend_q <= 3'h1;
			sysCfg_q <= 3'h1;
		end
		else
		begin
			if (regWrite && hit(regAddr, STLS_OFS_SYS_CFG))
				sysPend_q <= regWrData[2:0];
			if (regWrite && hit(regAddr, STLS_OFS_CTRL) && regWrData[STLS_BIT_POWER_CYCLE])
				sysCfg_q <= sysPend_q;
		end
	end

	// stored limits clamped to 300, reset to 0
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			for (int i = 0; i < SETS; i++)
				limits_q[i] <= STLS_LIMIT_RESET;
		end
		else if (regWrite && regAddr[AW-1:3] == STLS_OFS_LIMIT0[AW-1:3])
			limits_q[regAddr[2:0]] <= clampTo(regWrData, STLS_LIMIT_MAX);
	end

	// analog gain, offset and auto-offset capture
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			gain_q <= STLS_GAIN_RESET;
			offsetParam_q <= 16'h0000;
			capOffset_q <= 16'h0000;
		end
		else
		begin
			if (regWrite && hit(regAddr, STLS_OFS_GAIN))
				gain_q <= clampTo(regWrData, STLS_GAIN_MAX);
			if (regWrite && hit(regAddr, STLS_OFS_OFFSET))
				offsetParam_q <= regWrData;
			// capture 0 V reading on apply
			if (regWrite && hit(regAddr, STLS_OFS_CTRL) && regWrData[STLS_BIT_APPLY]
				&& sysCfg_q[STLS_BIT_AUTO_OFS])
				capOffset_q <= analogMilliVolt;
		end
	end

	assign zeroRef = sysCfg_q[STLS_BIT_AUTO_OFS] ? capOffset_q : offsetParam_q;
	assign deltaMv = (analogMilliVolt > zeroRef) ? 16'(analogMilliVolt - zeroRef) : 16'h0000;
	// percent = mV * gain / 1000
	assign analogLimit = (32'(deltaMv) * 32'(gain_q)) / 32'(STLS_MV_PER_V);

	// analog sets 0 and 1, digital otherwise
	always_comb
	begin
		if (sysCfg_q[STLS_BIT_ANALOG_EN] && setSel <= STLS_SET_ANALOG_LAST)
			activeLimit = (analogLimit > 32'(STLS_LIMIT_MAX)) ? STLS_LIMIT_MAX
				: analogLimit[15:0];
		else
			activeLimit = limits_q[setSel];
	end

	assign torqueClampedQ = clampSync_q && (producedTorque >= activeLimit);

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			torqueMax_q <= STLS_FULL_TORQUE;
			torque_clamped_status_out <= 1'b0;
		end
		else
		begin
			torqueMax_q <= clampSync_q ? activeLimit : STLS_FULL_TORQUE;
			torque_clamped_status_out <= torqueClampedQ;
		end
	end

	// tuning parameter registers
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			tune_q <= STLS_TUNE_AUTO;
			rigid_q <= 16'h0000;
			inertia_q <= 16'h0000;
			posGain_q <= 16'h0000;
			spdGain_q <= 16'h0000;
			spdInt_q <= 16'h0000;
			ffwd_q <= 16'h0000;
		end
		else if (regWrite)
		begin
			if (hit(regAddr, STLS_OFS_TUNE) && regWrData[1:0] != 2'b11)
				tune_q <= stls_tune_type'(regWrData[1:0]);
			if (hit(regAddr, STLS_OFS_RIGID))
				rigid_q <= regWrData;
			if (hit(regAddr, STLS_OFS_INERTIA))
				inertia_q <= regWrData;
			if (hit(regAddr, STLS_OFS_POSGAIN))
				posGain_q <= regWrData;
			if (hit(regAddr, STLS_OFS_SPDGAIN))
				spdGain_q <= regWrData;
			if (hit(regAddr, STLS_OFS_SPDINT))
				spdInt_q <= regWrData;
			if (hit(regAddr, STLS_OFS_FFWD))
				ffwd_q <= regWrData;
		end
	end

	// honored gains per mode; unused fields read zero
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			gains_q <= '0;
		else
		begin
			gains_q <= '0;
			gains_q.rigidity <= rigid_q;
			case (tune_q)
				// estimate limited to 50 times rotor
				STLS_TUNE_AUTO:
				begin
					gains_q.useEstimate <= 1'b1;
					gains_q.inertia <= clampTo(estInertia, STLS_AUTO_INERTIA_MAX);
				end
				STLS_TUNE_SEMI:
					gains_q.inertia <= clampTo(inertia_q, STLS_MANUAL_INERTIA_MAX);
				STLS_TUNE_MANUAL:
				begin
					gains_q.inertia <= clampTo(inertia_q, STLS_MANUAL_INERTIA_MAX);
					gains_q.spdGain <= spdGain_q;
					gains_q.spdInt <= spdInt_q;
					// servo lock gates position gain and feed-forward
					if (sysCfg_q[STLS_BIT_SERVO_LOCK])
					begin
						gains_q.posGain <= posGain_q;
						gains_q.feedFwd <= ffwd_q;
					end
				end
				default:
					gains_q.useEstimate <= 1'b0;
			endcase
		end
	end

	// read port: data in the cycle after the strobe only
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			regRdData_q <= 16'h0000;
		else if (!regRead)
			regRdData_q <= 16'h0000;
		else if (regAddr[AW-1:3] == STLS_OFS_LIMIT0[AW-1:3])
			regRdData_q <= limits_q[regAddr[2:0]];
		else
		begin
			case (regAddr)
				AW'(STLS_OFS_SYS_CFG): regRdData_q <= {13'h0000, sysPend_q};
				AW'(STLS_OFS_GAIN): regRdData_q <= gain_q;
				AW'(STLS_OFS_OFFSET): regRdData_q <= offsetParam_q;
				AW'(STLS_OFS_CTRL): regRdData_q <= capOffset_q;
				AW'(STLS_OFS_TUNE): regRdData_q <= {14'h0000, tune_q};
				AW'(STLS_OFS_RIGID): regRdData_q <= rigid_q;
				AW'(STLS_OFS_INERTIA): regRdData_q <= inertia_q;
				AW'(STLS_OFS_POSGAIN): regRdData_q <= posGain_q;
				AW'(STLS_OFS_SPDGAIN): regRdData_q <= spdGain_q;
				AW'(STLS_OFS_SPDINT): regRdData_q <= spdInt_q;
				AW'(STLS_OFS_FFWD): regRdData_q <= ffwd_q;
				AW'(STLS_OFS_STATUS): regRdData_q <= {9'h000, sysCfg_q, setSel, clampSync_q};
				default: regRdData_q <= 16'h0000;
			endcase
		end
	end

	// ceiling is full torque one cycle after clamp drops
	a_full_torque_off: assert property (@(posedge clk_sys) disable iff (reset)
		!clampSync_q |=> torqueMax_q == STLS_FULL_TORQUE) else $error("ceiling not 300");
	a_clamp_follows_set: assert property (@(posedge clk_sys) disable iff (reset)
		clampSync_q |=> torqueMax_q == $past(activeLimit)) else $error("clamp wrong");
	a_status_off_clamp: assert property (@(posedge clk_sys) disable iff (reset)
		!clampSync_q |=> !torque_clamped_status_out) else $error("status while off");
	a_status_on_reach: assert property (@(posedge clk_sys) disable iff (reset)
		clampSync_q && producedTorque >= activeLimit |=> torque_clamped_status_out)
		else $error("status missing");
	// config changes only on power cycle
	a_cfg_held: assert property (@(posedge clk_sys) disable iff (reset)
		!(regWrite && hit(regAddr, STLS_OFS_CTRL)) |=> $stable(sysCfg_q))
		else $error("config changed early");
	a_gain_range: assert property (@(posedge clk_sys) disable iff (reset)
		gain_q <= STLS_GAIN_MAX) else $error("gain out of range");
	// no position gain without servo lock
	a_lock_gates_pos: assert property (@(posedge clk_sys) disable iff (reset)
		!$past(sysCfg_q[STLS_BIT_SERVO_LOCK]) |-> gains_q.posGain == 16'h0000)
		else $error("position gain without lock");
	a_semi_no_est: assert property (@(posedge clk_sys) disable iff (reset)
		tune_q == STLS_TUNE_SEMI ##1 tune_q == STLS_TUNE_SEMI |-> !gains_q.useEstimate)
		else $error("estimate in semi mode");
	a_limit_range: assert property (@(posedge clk_sys) disable iff (reset)
		limits_q[setSel] <= STLS_LIMIT_MAX) else $error("limit out of range");
endmodule : stls_core

// ### verif/stls_host_model.sv
// stls_host_model: controller on the pin side, drives select and clamp pins.
// assumes the bench requests a set number and clamp level; pins change after an edge.
`timescale 1ns/1ps
module stls_host_model
(
	input wire logic clk_sys,
	input wire logic [2:0] setNum,
	input wire logic clampOn,
	output logic data_select_bit0,
	output logic data_select_bit1,
	output logic data_select_bit2,
	output logic torque_clamp_enable_in
);
	initial
	begin
		data_select_bit0 = 1'b0;
		data_select_bit1 = 1'b0;
		data_select_bit2 = 1'b0;
		torque_clamp_enable_in = 1'b0;
	end
	always @(posedge clk_sys)
	begin
		data_select_bit0 <= setNum[0];
		data_select_bit1 <= setNum[1];
		data_select_bit2 <= setNum[2];
		torque_clamp_enable_in <= clampOn;
	end
endmodule : stls_host_model

// ### verif/tb_top.sv
// tb_top: self-checking bench for stls_core with the pin-side model.
// assumes registers on the plain strobe port, pins settle within five edges.
`timescale 1ns/1ps
module tb_top;
	import stls_pkg::*;
	logic clk_sys = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0, clampOn = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [2:0] setNum = 3'h0;
	logic [15:0] regWrData = 16'h0000, analogMilliVolt = 16'h0000, rdVal;
	logic [15:0] producedTorque = 16'h0000, estInertia = 16'h0000, regRdData_q, torqueMax_q;
	logic sel0, sel1, sel2, clampPin, torque_clamped_status_out;
	stls_gains_type gains_q;
	int failures = 0, cmpCount = 0, cycles = 0;
	stls_host_model host_u (.clk_sys(clk_sys), .setNum(setNum), .clampOn(clampOn),
		.data_select_bit0(sel0), .data_select_bit1(sel1), .data_select_bit2(sel2),
		.torque_clamp_enable_in(clampPin));
	stls_core dut_u (.clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData_q(regRdData_q), .data_select_bit0(sel0), .data_select_bit1(sel1),
		.data_select_bit2(sel2), .torque_clamp_enable_in(clampPin),
		.analogMilliVolt(analogMilliVolt), .producedTorque(producedTorque),
		.estInertia(estInertia), .torqueMax_q(torqueMax_q),
		.torque_clamped_status_out(torque_clamped_status_out), .gains_q(gains_q));
	initial
	begin
		forever #50 clk_sys = ~clk_sys;
	end
	task print_verdict;
		$display("checks %0d mismatches %0d", cmpCount, failures);
		if (failures == 0 && cmpCount > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict
	// a hung wait is cut short here
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			failures++;
			print_verdict();
		end
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmpCount++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge clk_sys);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1 rdVal = regRdData_q;
	endtask : rd
	// two sync flops plus the model flop: five edges leave margin
	task sel(input logic [2:0] n, input logic c);
		@(posedge clk_sys);
		setNum <= n;
		clampOn <= c;
		repeat (5) @(posedge clk_sys);
		#1;
	endtask : sel
	task t_reset;
		chk(torqueMax_q, 16'h012C);
		rd(STLS_OFS_GAIN);
		chk(rdVal, 16'h001E);
		rd(8'h13);
		chk(rdVal, 16'h0000);
		rd(8'h20);
		chk(rdVal, 16'h0000);
	endtask : t_reset
	task t_digital;
		for (int i = 2; i < 8; i++)
			wr(8'h10 + 8'(i), 16'(i * 16));
		for (int i = 2; i < 8; i++)
		begin
			sel(3'(i), 1'b1);
			chk(torqueMax_q, 16'(i * 16));
		end
		wr(8'h17, 16'h0190);
		sel(3'h7, 1'b1);
		chk(torqueMax_q, 16'h012C);
		sel(3'h7, 1'b0);
		chk(torqueMax_q, 16'h012C);
	endtask : t_digital
	task t_analog;
		@(posedge clk_sys);
		analogMilliVolt <= 16'h1388;
		sel(3'h0, 1'b1);
		chk(torqueMax_q, 16'h0096);
		wr(STLS_OFS_GAIN, 16'h000A);
		sel(3'h1, 1'b1);
		chk(torqueMax_q, 16'h0032);
		wr(STLS_OFS_GAIN, 16'h001E);
		wr(STLS_OFS_OFFSET, 16'h03E8);
		sel(3'h1, 1'b1);
		chk(torqueMax_q, 16'h0078);
	endtask : t_analog
	task t_config;
		wr(8'h10, 16'h0045);
		wr(STLS_OFS_SYS_CFG, 16'h0000);
		sel(3'h0, 1'b1);
		chk(torqueMax_q, 16'h0078);
		wr(STLS_OFS_CTRL, 16'h0002);
		sel(3'h0, 1'b1);
		chk(torqueMax_q, 16'h0045);
		wr(STLS_OFS_SYS_CFG, 16'h0003);
		wr(STLS_OFS_CTRL, 16'h0002);
		// 200 mV zero reading applied while the capture is commanded
		analogMilliVolt <= 16'h00C8;
		wr(STLS_OFS_CTRL, 16'h0001);
		rd(STLS_OFS_CTRL);
		chk(rdVal, 16'h00C8);
		@(posedge clk_sys);
		analogMilliVolt <= 16'h1450;
		sel(3'h0, 1'b1);
		chk(torqueMax_q, 16'h0096);
	endtask : t_config
	task t_status;
		@(posedge clk_sys);
		producedTorque <= 16'h0020;
		sel(3'h2, 1'b1);
		chk({15'h0000, torque_clamped_status_out}, 16'h0001);
		@(posedge clk_sys);
		producedTorque <= 16'h001F;
		sel(3'h2, 1'b1);
		chk({15'h0000, torque_clamped_status_out}, 16'h0000);
		@(posedge clk_sys);
		producedTorque <= 16'h0020;
		sel(3'h2, 1'b0);
		chk({15'h0000, torque_clamped_status_out}, 16'h0000);
	endtask : t_status
	task t_tune;
		@(posedge clk_sys);
		estInertia <= 16'h0050;
		wr(STLS_OFS_RIGID, 16'h0005);
		wr(STLS_OFS_INERTIA, 16'h0046);
		wr(STLS_OFS_POSGAIN, 16'h0007);
		wr(STLS_OFS_SPDGAIN, 16'h0009);
		wr(STLS_OFS_SPDINT, 16'h000B);
		wr(STLS_OFS_FFWD, 16'h000C);
		sel(3'h0, 1'b0);
		chk(gains_q.rigidity, 16'h0005);
		chk(gains_q.spdGain, 16'h0000);
		chk(gains_q.spdInt, 16'h0000);
		chk(gains_q.inertia, 16'h0032);
		chk({15'h0000, gains_q.useEstimate}, 16'h0001);
		wr(STLS_OFS_TUNE, 16'h0001);
		sel(3'h0, 1'b0);
		chk(gains_q.inertia, 16'h0046);
		chk({15'h0000, gains_q.useEstimate}, 16'h0000);
		chk(gains_q.spdGain, 16'h0000);
		wr(STLS_OFS_TUNE, 16'h0002);
		wr(STLS_OFS_TUNE, 16'h0003);
		wr(STLS_OFS_INERTIA, 16'h00C8);
		sel(3'h0, 1'b0);
		chk(gains_q.spdGain, 16'h0009);
		chk(gains_q.posGain, 16'h0000);
		chk(gains_q.feedFwd, 16'h0000);
		chk(gains_q.spdInt, 16'h000B);
		chk(gains_q.inertia, 16'h0064);
		wr(STLS_OFS_SYS_CFG, 16'h0005);
		wr(STLS_OFS_CTRL, 16'h0002);
		sel(3'h0, 1'b0);
		chk(gains_q.posGain, 16'h0007);
		chk(gains_q.feedFwd, 16'h000C);
	endtask : t_tune
	initial
	begin
		repeat (4) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		#1;
		t_reset();
		t_digital();
		t_analog();
		t_config();
		t_status();
		t_tune();
		print_verdict();
	end
endmodule : tb_top
